// File: pfm_measure.sv
// Period or frequency measurement engine with Avalon-MM registers
// Assumes ZC inputs are synchronous zero-crossing comparator levels
//
// Functional notes
// - Measure period on selected channel plus repetition index, microseconds
// - Option tens digit: period or kHz
// - Time all cycles on 60 ns timebase
// - Each repetition waits at most timeout
// - Timeout stores -99999 (Q24.8) instead of result
// - Range codes 1-4 select input gain
// - Cycles bounded at zero-threshold crossings
`timescale 1ns/1ns
module pfm_measure #(
	parameter int TMO_CYC = pfm_pkg::TMO_UNIT_CYC
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Avalon-MM slave
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Comparator levels, high above zero
	input wire logic [7:0] ZC,
	// Front end
	output logic [1:0] GAIN,
	output logic BUSY
);
	typedef enum logic [2:0] {ST_IDLE, ST_SETTLE, ST_ARM, ST_COUNT, ST_DIV, ST_SCALE,
		ST_STORE} pfm_state_e;

	pfm_tb_if tb();
	pfm_timebase #(.TMO_CYC(TMO_CYC)) u_tb (.CLK(CLK), .RESET(RESET), .tb(tb.gen));

	pfm_state_e state_r;
	logic [7:0] option_r;
	logic [2:0] channel_r;
	logic [15:0] cycles_r;
	logic [15:0] timeout_r;
	logic [4:0] reps_r;
	logic [31:0] mult_r;
	logic [31:0] offset_r;
	logic [31:0] result_mem [pfm_pkg::RESULT_DEPTH];
	logic done_r;
	logic badrange_r;
	logic [4:0] rep_r;
	logic [15:0] seen_r;
	logic [31:0] ticks_r;
	logic [15:0] tmo_r;
	logic zc_prev_r;
	logic [63:0] num_r;
	logic [40:0] rem_r;
	logic [39:0] den_r;
	logic [6:0] step_r;
	logic [31:0] value_r;
	logic restart_r;

	logic take_wr;
	logic start;
	logic freq_mode;
	logic [3:0] range_code;
	logic range_ok;
	logic zc_now;
	logic crossing;
	logic timed_out;
	logic [40:0] rem_shift;
	logic [63:0] product;
	logic [3:0] res_idx;

	assign take_wr = AVS_WRITE && !AVS_WAITREQUEST;
	assign start = take_wr && AVS_ADDRESS == pfm_pkg::OFS_CTRL
		&& AVS_WRITEDATA[pfm_pkg::CTRL_START_BIT] && state_r == ST_IDLE;
	assign freq_mode = option_r >= pfm_pkg::OPT_FREQ_BASE;
	assign range_code = freq_mode ? 4'(option_r - pfm_pkg::OPT_FREQ_BASE) : option_r[3:0];
	assign range_ok = option_r < pfm_pkg::OPT_LIMIT && range_code >= pfm_pkg::RANGE_MIN
		&& range_code <= pfm_pkg::RANGE_MAX;
	assign zc_now = ZC[3'(channel_r + 3'(rep_r))];
	assign crossing = zc_now && !zc_prev_r;
	assign timed_out = tmo_r >= timeout_r;
	assign rem_shift = {rem_r[39:0], num_r[63]};
	assign product = $signed(value_r) * $signed(mult_r);
	assign res_idx = rep_r[3:0];
	assign tb.restart = restart_r;

	// Avalon handshake: one wait state per access
	always_ff @(posedge CLK) begin
		if (RESET) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= '0;
		end else if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
			AVS_WAITREQUEST <= 1'b0;
			AVS_READDATA <= '0;
			if (AVS_READ) begin
				unique case (AVS_ADDRESS)
				pfm_pkg::OFS_STATUS: begin
					AVS_READDATA[pfm_pkg::STAT_BUSY_BIT] <= state_r != ST_IDLE;
					AVS_READDATA[pfm_pkg::STAT_DONE_BIT] <= done_r;
					AVS_READDATA[pfm_pkg::STAT_BADRANGE_BIT] <= badrange_r;
				end
				pfm_pkg::OFS_OPTION: AVS_READDATA <= 32'(option_r);
				pfm_pkg::OFS_CHANNEL: AVS_READDATA <= 32'(channel_r);
				pfm_pkg::OFS_CYCLES: AVS_READDATA <= 32'(cycles_r);
				pfm_pkg::OFS_TIMEOUT: AVS_READDATA <= 32'(timeout_r);
				pfm_pkg::OFS_REPS: AVS_READDATA <= 32'(reps_r);
				pfm_pkg::OFS_MULT: AVS_READDATA <= mult_r;
				pfm_pkg::OFS_OFFSET: AVS_READDATA <= offset_r;
				default: begin
					if (AVS_ADDRESS >= pfm_pkg::OFS_RESULT && AVS_ADDRESS[1:0] == 2'h0) begin
						AVS_READDATA <= result_mem[AVS_ADDRESS[5:2]];
					end
				end
				endcase
			end
		end else begin
			AVS_WAITREQUEST <= 1'b1;
		end
	end

	// Configuration registers, ignored while busy
	always_ff @(posedge CLK) begin
		if (RESET) begin
			option_r <= pfm_pkg::OPTION_RST;
			channel_r <= '0;
			cycles_r <= pfm_pkg::CYCLES_RST;
			timeout_r <= pfm_pkg::TIMEOUT_RST;
			reps_r <= pfm_pkg::REPS_RST;
			mult_r <= pfm_pkg::MULT_RST;
			offset_r <= '0;
		end else if (take_wr && state_r == ST_IDLE) begin
			unique case (AVS_ADDRESS)
			pfm_pkg::OFS_OPTION: option_r <= AVS_WRITEDATA[7:0];
			pfm_pkg::OFS_CHANNEL: channel_r <= AVS_WRITEDATA[2:0];
			pfm_pkg::OFS_CYCLES: cycles_r <= AVS_WRITEDATA[15:0];
			pfm_pkg::OFS_TIMEOUT: timeout_r <= AVS_WRITEDATA[15:0];
			pfm_pkg::OFS_REPS: reps_r <= AVS_WRITEDATA[4:0];
			pfm_pkg::OFS_MULT: mult_r <= AVS_WRITEDATA;
			pfm_pkg::OFS_OFFSET: offset_r <= AVS_WRITEDATA;
			default: ;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			GAIN <= '0;
			BUSY <= 1'b0;
		end else begin
			GAIN <= range_ok ? 2'(range_code - pfm_pkg::RANGE_MIN) : 2'h0;
			BUSY <= state_r != ST_IDLE;
		end
	end

	// Edge history of selected channel plus repetition index
	always_ff @(posedge CLK) begin
		if (RESET) begin
			zc_prev_r <= 1'b0;
		end else begin
			zc_prev_r <= zc_now;
		end
	end

	// Sequencer
	always_ff @(posedge CLK) begin
		if (RESET) begin
			state_r <= ST_IDLE;
			done_r <= 1'b0;
			badrange_r <= 1'b0;
			rep_r <= '0;
			seen_r <= '0;
			ticks_r <= '0;
			tmo_r <= '0;
			num_r <= '0;
			rem_r <= '0;
			den_r <= '0;
			step_r <= '0;
			value_r <= '0;
			restart_r <= 1'b0;
		end else begin
			restart_r <= 1'b0;
			unique case (state_r)
			ST_IDLE: begin
				if (start) begin
					done_r <= 1'b0;
					badrange_r <= !range_ok;
					rep_r <= '0;
					restart_r <= 1'b1;
					tmo_r <= '0;
					state_r <= ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				seen_r <= '0;
				ticks_r <= '0;
				state_r <= ST_ARM;
			end
			ST_ARM: begin
				if (tb.tick_tmo) begin
					tmo_r <= tmo_r + 16'h0001;
				end
				if (timed_out || !range_ok || cycles_r == '0) begin
					value_r <= pfm_pkg::ERR_VALUE;
					state_r <= ST_STORE;
				end else if (crossing) begin
					state_r <= ST_COUNT;
				end
			end
			ST_COUNT: begin
				if (tb.tick_tmo) begin
					tmo_r <= tmo_r + 16'h0001;
				end
				// count fine ticks over all cycles
				if (tb.tick_fine) begin
					ticks_r <= ticks_r + 32'h0000_0001;
				end
				if (timed_out) begin
					value_r <= pfm_pkg::ERR_VALUE;
					state_r <= ST_STORE;
				end else if (crossing && seen_r == cycles_r - 16'h0001) begin
					if (freq_mode) begin
						num_r <= 64'(cycles_r) * 64'(pfm_pkg::FREQ_SCALE) << pfm_pkg::RES_FRAC;
						den_r <= 40'(ticks_r) * 40'(pfm_pkg::FINE_TICK_NS);
					end else begin
						num_r <= 64'(ticks_r) * 64'(pfm_pkg::FINE_TICK_NS) << pfm_pkg::RES_FRAC;
						den_r <= 40'(cycles_r) * 40'(pfm_pkg::NS_PER_US);
					end
					rem_r <= '0;
					step_r <= '0;
					state_r <= ST_DIV;
				end else if (crossing) begin
					seen_r <= seen_r + 16'h0001;
				end
			end
			ST_DIV: begin
				if (den_r == '0) begin
					value_r <= pfm_pkg::ERR_VALUE;
					state_r <= ST_STORE;
				end else if (step_r == 7'(pfm_pkg::DIV_STEPS)) begin
					value_r <= num_r > 64'(pfm_pkg::SAT_MAX) ? pfm_pkg::SAT_MAX : num_r[31:0];
					state_r <= ST_SCALE;
				end else begin
					if (rem_shift >= {1'b0, den_r}) begin
						rem_r <= rem_shift - {1'b0, den_r};
						num_r <= {num_r[62:0], 1'b1};
					end else begin
						rem_r <= rem_shift;
						num_r <= {num_r[62:0], 1'b0};
					end
					step_r <= step_r + 7'h01;
				end
			end
			ST_SCALE: begin
				value_r <= 32'(product >>> pfm_pkg::MULT_FRAC) + offset_r;
				state_r <= ST_STORE;
			end
			ST_STORE: begin
				if (rep_r + 5'h01 >= reps_r || rep_r + 5'h01 >= 5'(pfm_pkg::RESULT_DEPTH)) begin
					done_r <= 1'b1;
					state_r <= ST_IDLE;
				end else begin
					rep_r <= rep_r + 5'h01;
					restart_r <= 1'b1;
					tmo_r <= '0;
					state_r <= ST_SETTLE;
				end
			end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (state_r == ST_STORE) begin
			result_mem[res_idx] <= value_r;
		end
	end
endmodule

// File: pfm_pkg.sv
// Constants shared by the period and frequency measurement block
// Assumes a single 125 MHz clock and an Avalon-MM register master
package pfm_pkg;
	// Clock and timebase
	localparam int CLK_PERIOD_NS = 8;
	localparam int FINE_TICK_NS = 60;
	localparam int TMO_UNIT_NS = 10_000_000;
	localparam int TMO_UNIT_CYC = TMO_UNIT_NS / CLK_PERIOD_NS;
	localparam logic [6:0] ACC_STEP = 7'(CLK_PERIOD_NS);
	localparam logic [6:0] ACC_WRAP = 7'(FINE_TICK_NS);
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_OPTION = 8'h08;
	localparam logic [7:0] OFS_CHANNEL = 8'h0c;
	localparam logic [7:0] OFS_CYCLES = 8'h10;
	localparam logic [7:0] OFS_TIMEOUT = 8'h14;
	localparam logic [7:0] OFS_REPS = 8'h18;
	localparam logic [7:0] OFS_MULT = 8'h1c;
	localparam logic [7:0] OFS_OFFSET = 8'h20;
	localparam logic [7:0] OFS_RESULT = 8'h40;
	localparam int RESULT_DEPTH = 16;
	// Field positions
	localparam int CTRL_START_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_BADRANGE_BIT = 2;
	// Option code decode: tens digit selects output, units digit range
	localparam logic [7:0] OPT_FREQ_BASE = 8'h0a;
	localparam logic [7:0] OPT_LIMIT = 8'h14;
	localparam logic [3:0] RANGE_MIN = 4'h1;
	localparam logic [3:0] RANGE_MAX = 4'h4;
	// Reset values
	localparam logic [7:0] OPTION_RST = 8'h01;
	localparam logic [15:0] CYCLES_RST = 16'h0001;
	localparam logic [15:0] TIMEOUT_RST = 16'h0064;
	localparam logic [4:0] REPS_RST = 5'h01;
	localparam logic [31:0] MULT_RST = 32'h0001_0000;
	// Arithmetic: results are signed Q24.8, multiplier Q16.16
	localparam int RES_FRAC = 8;
	localparam int MULT_FRAC = 16;
	localparam logic [31:0] NS_PER_US = 32'h0000_03e8;
	localparam logic [31:0] FREQ_SCALE = 32'h000f_4240;
	localparam logic [31:0] ERR_VALUE = 32'hfe79_6100;
	localparam logic [31:0] SAT_MAX = 32'h7fff_ffff;
	localparam int DIV_STEPS = 64;
endpackage

// File: pfm_tb_if.sv
// Timebase link between the measurement core and its tick generator
// Assumes both ends share the one system clock
`timescale 1ns/1ns
interface pfm_tb_if;
	logic restart;
	logic tick_fine;
	logic tick_tmo;
	modport ctl (output restart, input tick_fine, input tick_tmo);
	modport gen (input restart, output tick_fine, output tick_tmo);
endinterface

// File: pfm_timebase.sv
// Fine 60 ns tick and coarse timeout tick generator
// Assumes CLK at 125 MHz; restart realigns both tick phases
`timescale 1ns/1ns
module pfm_timebase #(
	parameter int TMO_CYC = pfm_pkg::TMO_UNIT_CYC
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Tick link
	pfm_tb_if.gen tb
);
	logic [6:0] acc_r;
	logic [31:0] tmo_cnt_r;

	always_ff @(posedge CLK) begin
		if (RESET || tb.restart) begin
			acc_r <= '0;
			tb.tick_fine <= 1'b0;
		end else if (acc_r + pfm_pkg::ACC_STEP >= pfm_pkg::ACC_WRAP) begin
			acc_r <= acc_r + pfm_pkg::ACC_STEP - pfm_pkg::ACC_WRAP;
			tb.tick_fine <= 1'b1;
		end else begin
			acc_r <= acc_r + pfm_pkg::ACC_STEP;
			tb.tick_fine <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET || tb.restart) begin
			tmo_cnt_r <= '0;
			tb.tick_tmo <= 1'b0;
		end else if (tmo_cnt_r == 32'(TMO_CYC - 1)) begin
			tmo_cnt_r <= '0;
			tb.tick_tmo <= 1'b1;
		end else begin
			tmo_cnt_r <= tmo_cnt_r + 32'h0000_0001;
			tb.tick_tmo <= 1'b0;
		end
	end
endmodule

// File: pfm_monitor.sv
// Bus and measurement checker for pfm_measure
// Assumes a bind onto the top module ports
`timescale 1ns/1ns
module pfm_monitor #(
	parameter int TMO_CYC = 100
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Register bus
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	// Front end
	input wire logic [7:0] ZC,
	input wire logic [1:0] GAIN,
	input wire logic BUSY
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	logic rq;
	logic ack;
	assign rq = AVS_READ || AVS_WRITE;
	assign ack = !AVS_WAITREQUEST;
	a_ack_one_cycle: assert property (ack |=> !ack)
		else $error("ack held over one cycle");
	a_ack_after_take: assert property (rq && !ack |=> ack)
		else $error("no ack one cycle after request");
	a_ack_needs_req: assert property (ack |-> $past(rq))
		else $error("ack without request");
	a_start_sets_busy: assert property ($rose(BUSY) |-> $past(AVS_WRITE && ack
		&& AVS_ADDRESS == pfm_pkg::OFS_CTRL && AVS_WRITEDATA[pfm_pkg::CTRL_START_BIT], 2))
		else $error("busy rose without start write");
	a_gain_hold_busy: assert property (BUSY && $past(BUSY) |-> $stable(GAIN))
		else $error("gain changed during run");
	a_rdata_stands: assert property (AVS_WAITREQUEST |-> $stable(AVS_READDATA))
		else $error("read data moved between accesses");
	a_reset_idle: assert property ($fell(RESET) |-> !BUSY && GAIN == 2'h0 && !ack)
		else $error("not idle after reset");
	a_reads_zero: assert property (ack && AVS_READ && (AVS_ADDRESS == pfm_pkg::OFS_CTRL
		|| AVS_ADDRESS == 8'h24) |-> AVS_READDATA == 32'h0)
		else $error("control or unmapped read not zero");
	c_start: cover property ($rose(BUSY));
	c_finish: cover property ($fell(BUSY));
	c_result: cover property (ack && AVS_READ && AVS_ADDRESS >= pfm_pkg::OFS_RESULT);
endmodule

// File: pfm_sig_src.sv
// Square wave source seen through per channel comparators
// Assumes one system clock; a silent channel never crosses
`timescale 1ns/1ns
module pfm_sig_src (
	// Clock
	input wire logic clk,
	// Source setup
	input wire logic [7:0] on_mask,
	input wire logic [7:0] half_cyc,
	// Comparator levels
	output logic [7:0] zc
);
	logic [7:0] cnt_r = 8'h00;
	logic lvl_r = 1'b0;
	always @(posedge clk) begin
		cnt_r <= (cnt_r >= half_cyc - 8'h01) ? 8'h00 : cnt_r + 8'h01;
		if (cnt_r >= half_cyc - 8'h01)
			lvl_r <= !lvl_r;
	end
	assign zc = on_mask & {8{lvl_r}};
endmodule

// File: tb_top.sv
// Self-checking bench for pfm_measure with a signal source
// Assumes a short timeout unit of 100 clock cycles
`timescale 1ns/1ns
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [7:0] on_m = 8'h00;
	logic [7:0] hc = 8'h20;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdv;
	logic [31:0] rdata;
	logic wreq;
	logic busy;
	logic [1:0] gain;
	logic [7:0] zc;
	int miscompares = 0;
	int num_checks = 0;
	always #4 clk = ~clk;
	pfm_measure #(.TMO_CYC(100)) dut (.CLK(clk), .RESET(rst), .AVS_ADDRESS(adr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wreq), .ZC(zc), .GAIN(gain), .BUSY(busy));
	pfm_sig_src src (.clk(clk), .on_mask(on_m), .half_cyc(hc), .zc(zc));
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g, input int tol);
		num_checks++;
		if (g !== e && ($isunknown(g) || $signed(g - e) > tol || $signed(e - g) > tol)) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 40);
		rdv = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 40) begin
			miscompares++;
			$display("Error waitrequest expected 0 seen 1");
			give_verdict();
		end
		@(posedge clk);
	endtask
	function automatic logic [31:0] expv(input logic fr, input int h, input int m, input int o);
		longint b;
		b = fr ? 64'd16000000 / h : 64'd4096 * h / 1000;
		return 32'(((b * m) >>> 16) + o);
	endfunction
	task run(input int opt, input int cy, input int rp, input int ch, input int h,
		input int msk, input int ml, input int of);
		int n;
		int tol;
		logic ok;
		ok = opt % 10 >= 1 && opt % 10 <= 4 && opt <= 14;
		hc <= 8'(h);
		on_m <= 8'(msk);
		bus(1, pfm_pkg::OFS_OPTION, opt);
		bus(1, pfm_pkg::OFS_CYCLES, cy);
		chk("gain", ok ? opt % 10 - 1 : 0, 32'(gain), 0);
		bus(1, pfm_pkg::OFS_TIMEOUT, 32'h14);
		bus(1, pfm_pkg::OFS_REPS, rp);
		bus(1, pfm_pkg::OFS_CHANNEL, ch);
		bus(1, pfm_pkg::OFS_MULT, ml);
		bus(1, pfm_pkg::OFS_OFFSET, of);
		bus(1, pfm_pkg::OFS_CTRL, 1);
		bus(1, pfm_pkg::OFS_OPTION, 32'h0c);
		n = 0;
		do begin
			bus(0, pfm_pkg::OFS_STATUS, 0);
			n++;
		end while (rdv[1] !== 1'b1 && n < 5000);
		if (n >= 5000 && rdv[1] !== 1'b1) begin
			miscompares++;
			$display("Error done expected 1 seen 0");
			give_verdict();
		end
		chk("done", 1, 32'(rdv[1]), 0);
		chk("bad range", 32'(!ok), 32'(rdv[2]), 0);
		chk("busy bit", 0, 32'(rdv[0]), 0);
		chk("busy pin", 0, 32'(busy), 0);
		tol = (opt >= 10 ? 16000000 / h * 60 / (cy * 16 * h + 1) + 4 : 20) * (ml >> 16);
		for (int r = 0; r < rp; r++) begin
			bus(0, pfm_pkg::OFS_RESULT + 8'(4 * r), 0);
			if (ok && cy > 0 && msk[(ch + r) % 8])
				chk("result", expv(opt >= 10, h, ml, of), rdv, tol);
			else
				chk("error value", pfm_pkg::ERR_VALUE, rdv, 0);
		end
		bus(0, pfm_pkg::OFS_OPTION, 0);
		chk("option kept", 32'(opt), rdv, 0);
		$display("run option %0d done", opt);
	endtask
	initial begin
		logic [7:0] ra[5] = '{8'h08, 8'h10, 8'h14, 8'h18, 8'h1c};
		logic [31:0] rv[5] = '{32'h1, 32'h1, 32'h64, 32'h1, 32'h10000};
		void'($urandom(80018));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (ra[i]) begin
			bus(0, ra[i], 0);
			chk("reset value", rv[i], rdv, 0);
		end
		bus(1, 8'h24, 32'h5a5a5a5a);
		bus(0, 8'h24, 0);
		chk("unmapped", 0, rdv, 0);
		$display("register test done");
		run(5, 4, 2, 0, 25, 255, 32'h10000, 0);
		run(1, 0, 1, 0, 25, 255, 32'h10000, 0);
		run(11, 4, 3, 6, 30, 8'h81, 32'h10000, 0);
		for (int k = 1; k <= 4; k++)
			run(k + (k % 2) * 10, 4 + k, 2, k, 20 + 10 * k, 255, 32'h20000, 16);
		repeat (4)
			run($urandom_range(1, 4) + 10 * $urandom_range(0, 1), $urandom_range(4, 10),
				$urandom_range(1, 3), $urandom_range(0, 7), $urandom_range(20, 60),
				$urandom_range(0, 255), 32'h10000 << $urandom_range(0, 1),
				$urandom_range(0, 255));
		give_verdict();
	end
endmodule
bind pfm_measure pfm_monitor #(.TMO_CYC(TMO_CYC)) mon (.CLK(CLK), .RESET(RESET),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .ZC(ZC), .GAIN(GAIN), .BUSY(BUSY));
